// file: logic/tpc_pkg.sv
// constants for the transmit path configuration and timer interrupt block
// assumes one host control port shared with other channels, 8-bit data
package tpc_pkg;

  // ==========================================================
  // addresses: upper nibble 0 is global, otherwise the channel
  localparam logic [11:0] ADDR_TIMER_EN = 12'h00C;
  localparam logic [11:0] ADDR_TIMER_ST = 12'h00D;
  localparam logic [7:0]  OFS_LINE_STD  = 8'h20;
  localparam logic [7:0]  OFS_TJA_CFG   = 8'h21;
  localparam logic [7:0]  OFS_TX_CFG0   = 8'h22;
  localparam logic [3:0]  GLOBAL_PAGE   = 4'h0;

  // ==========================================================
  // field positions
  localparam int BIT_TIMER_EN    = 0;
  localparam int BIT_TIMER_FLAG  = 0;
  localparam int BIT_LINE_STD    = 0;
  localparam int BIT_JIT_MEASURE = 5;
  localparam int BIT_ATT_WIDE    = 4;
  localparam int BIT_ATT_EN      = 3;
  localparam int BIT_ATT_DEPTH   = 1;
  localparam int BIT_ATT_BW      = 0;
  localparam int BIT_TX_PDOWN    = 4;
  localparam int BIT_TX_INVERT   = 3;
  localparam int BIT_TX_EDGE     = 2;
  localparam int BIT_TX_MODE     = 0;

  // ==========================================================
  // reset values, already trimmed to the writable width
  localparam logic       RST_TIMER_EN = 1'b0;
  localparam logic       RST_LINE_STD = 1'b0;
  localparam logic [5:0] RST_TJA_CFG  = 6'h10;
  localparam logic [4:0] RST_TX_CFG0  = 5'h00;

  // ==========================================================
  // encoder modes; any code with bit 1 set bypasses the encoder
  localparam logic [1:0] MODE_SUBST = 2'b00;
  localparam logic [1:0] MODE_AMI   = 2'b01;

  // ==========================================================
  // attenuator depth in bits and transfer corners in millihertz
  localparam logic [7:0]  DEPTH_DEEP   = 8'h80;
  localparam logic [7:0]  DEPTH_MID    = 8'h40;
  localparam logic [7:0]  DEPTH_SHORT  = 8'h20;
  localparam logic [12:0] CORNER_T1_LO = 13'h1388;
  localparam logic [12:0] CORNER_E1_LO = 13'h1A72;
  localparam logic [12:0] CORNER_T1_HI = 13'h04EC;
  localparam logic [12:0] CORNER_E1_HI = 13'h0366;

  // ==========================================================
  // timing
  localparam int CLOCK_HZ       = 100_000_000;
  localparam int TIMER_PERIOD_S = 1;
  localparam int TIMER_CYCLES   = TIMER_PERIOD_S * CLOCK_HZ;
  localparam int SYNC_STAGES    = 3;

endpackage

// file: logic/tpc_second_timer.sv
// free running one-second timer for the global interrupt
// assumes the 100 MHz system clock; the period is a parameter for simulation
`timescale 1ns/1ps
module tpc_second_timer
  import tpc_pkg::*;
#(
  parameter int PERIOD_CYCLES = TIMER_CYCLES
) (
  input  wire logic clock,
  input  wire logic reset,
  output logic      expire
);

  localparam int CW = $clog2(PERIOD_CYCLES);

  initial begin
    if (PERIOD_CYCLES < 2) begin
      $error("timer period must be at least two cycles");
    end
  end

  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;
  logic          wrap;

  // wrap at the last cycle of the period
  assign wrap    = (count_q == CW'(PERIOD_CYCLES - 1));
  assign count_d = wrap ? '0 : count_q + 1'b1;

  // ==========================================================
  // counter; expire is a one-cycle pulse once per period
  always_ff @(posedge clock) begin
    if (reset) begin
      count_q <= '0;
      expire  <= 1'b0;
    end else begin
      count_q <= count_d;
      expire  <= wrap;
    end
  end

endmodule

// file: logic/tpc_tx_path_config.sv
// register bank and transmit front end for one line-interface channel
// assumes a host control port with single-cycle read and write strobes;
// transmit pins arrive asynchronously and run far below the system clock
`timescale 1ns/1ps
module tpc_tx_path_config
  import tpc_pkg::*;
#(
  parameter logic [3:0] CHANNEL       = 4'h1,
  parameter int         PERIOD_CYCLES = TIMER_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        reset,
  // host control port
  input  wire logic        reg_cs,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [11:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic [7:0]       reg_rdata,
  output logic             reg_rvalid,
  output logic             timer_irq,
  // system side transmit pins
  input  wire logic        tx_channel_clock,
  input  wire logic        tx_single_rail_data,
  input  wire logic        tx_positive_rail_data,
  input  wire logic        tx_negative_rail_data,
  // towards the line side
  output logic             tx_bit_strobe,
  output logic             tx_line_pos,
  output logic             tx_line_neg,
  output logic             tx_driver_oe,
  output logic             tx_power_down,
  output logic             tx_t1_mode,
  output logic             tx_subst_hdb3,
  output logic             tx_subst_b8zs,
  output logic             tx_ami_en,
  output logic             tx_shaper_en,
  output logic             tx_encoder_bypass,
  // jitter attenuator settings
  output logic             tx_atten_enable,
  output logic             tx_atten_wide_limit,
  output logic             tx_jitter_measure_mode,
  output logic [7:0]       tx_atten_depth_bits,
  output logic [12:0]      tx_atten_corner_mhz
);

  initial begin
    if (CHANNEL == GLOBAL_PAGE) begin
      $error("channel page 0 is reserved for global registers");
    end
  end

  // ==========================================================
  // address decoding
  function automatic logic addr_hit(input logic [11:0] a,
                                    input logic [11:0] target);
    addr_hit = (a == target);
  endfunction

  logic hit_timer_en;
  logic hit_timer_st;
  logic hit_line_std;
  logic hit_tja_cfg;
  logic hit_tx_cfg0;
  logic wr_stb;
  logic rd_stb;

  assign wr_stb       = reg_cs & reg_wr;
  assign rd_stb       = reg_cs & reg_rd;
  assign hit_timer_en = addr_hit(reg_addr, ADDR_TIMER_EN);
  assign hit_timer_st = addr_hit(reg_addr, ADDR_TIMER_ST);
  assign hit_line_std = addr_hit(reg_addr, {CHANNEL, OFS_LINE_STD});
  assign hit_tja_cfg  = addr_hit(reg_addr, {CHANNEL, OFS_TJA_CFG});
  assign hit_tx_cfg0  = addr_hit(reg_addr, {CHANNEL, OFS_TX_CFG0});

  // ==========================================================
  // configuration registers; only the defined bits are stored
  logic       timer_en_q;
  logic       line_std_q;
  logic [5:0] tja_cfg_q;
  logic [4:0] tx_cfg0_q;

  // timer interrupt enable
  always_ff @(posedge clock) begin
    if (reset) begin
      timer_en_q <= RST_TIMER_EN;
    end else if (wr_stb && hit_timer_en) begin
      timer_en_q <= reg_wdata[BIT_TIMER_EN];
    end
  end

  // line standard select
  always_ff @(posedge clock) begin
    if (reset) begin
      line_std_q <= RST_LINE_STD;
    end else if (wr_stb && hit_line_std) begin
      line_std_q <= reg_wdata[BIT_LINE_STD];
    end
  end

  // jitter attenuator configuration, bits 7:6 are dropped
  always_ff @(posedge clock) begin
    if (reset) begin
      tja_cfg_q <= RST_TJA_CFG;
    end else if (wr_stb && hit_tja_cfg) begin
      tja_cfg_q <= reg_wdata[5:0];
    end
  end

  // transmit configuration 0, bits 7:5 are dropped
  always_ff @(posedge clock) begin
    if (reset) begin
      tx_cfg0_q <= RST_TX_CFG0;
    end else if (wr_stb && hit_tx_cfg0) begin
      tx_cfg0_q <= reg_wdata[4:0];
    end
  end

  // ==========================================================
  // one-second timer and its sticky expiry flag
  logic timer_expire;
  logic timer_expiry_flag_q;
  logic flag_clear;

  tpc_second_timer #(
    .PERIOD_CYCLES (PERIOD_CYCLES)
  ) u_timer (
    .clock  (clock),
    .reset  (reset),
    .expire (timer_expire)
  );

  // a write of zero leaves the flag alone
  assign flag_clear = wr_stb & hit_timer_st & reg_wdata[BIT_TIMER_FLAG];

  // set wins over a clear in the same cycle so no expiry is lost
  always_ff @(posedge clock) begin
    if (reset) begin
      timer_expiry_flag_q <= 1'b0;
    end else if (timer_expire) begin
      timer_expiry_flag_q <= 1'b1;
    end else if (flag_clear) begin
      timer_expiry_flag_q <= 1'b0;
    end
  end

  // level request, drops as soon as the flag is cleared or masked
  assign timer_irq = timer_expiry_flag_q & timer_en_q;

  // ==========================================================
  // read back; reserved bits and unmapped addresses give zero
  logic [7:0] rdata_d;

  assign rdata_d =
    hit_timer_en ? {7'h00, timer_en_q} :
    hit_timer_st ? {7'h00, timer_expiry_flag_q} :
    hit_line_std ? {7'h00, line_std_q} :
    hit_tja_cfg  ? {2'h0, tja_cfg_q} :
    hit_tx_cfg0  ? {3'h0, tx_cfg0_q} :
                   8'h00;

  // data lands one cycle after the read strobe
  always_ff @(posedge clock) begin
    if (reset) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata  <= rd_stb ? rdata_d : reg_rdata;
      reg_rvalid <= rd_stb;
    end
  end

  // ==========================================================
  // field extraction
  logic       f_measure;
  logic       f_wide;
  logic       f_att_en;
  logic [1:0] f_depth;
  logic       f_bw;
  logic       f_pdown;
  logic       f_invert;
  logic       f_edge;
  logic [1:0] f_mode;

  assign f_measure = tja_cfg_q[BIT_JIT_MEASURE];
  assign f_wide    = tja_cfg_q[BIT_ATT_WIDE];
  assign f_att_en  = tja_cfg_q[BIT_ATT_EN];
  assign f_depth   = tja_cfg_q[BIT_ATT_DEPTH +: 2];
  assign f_bw      = tja_cfg_q[BIT_ATT_BW];
  assign f_pdown   = tx_cfg0_q[BIT_TX_PDOWN];
  assign f_invert  = tx_cfg0_q[BIT_TX_INVERT];
  assign f_edge    = tx_cfg0_q[BIT_TX_EDGE];
  assign f_mode    = tx_cfg0_q[BIT_TX_MODE +: 2];

  // ==========================================================
  // decoded settings for the datapath
  logic [7:0]  depth_d;
  logic [12:0] corner_d;
  logic        bypass_d;
  logic        subst_d;
  logic        ami_d;

  // codes 10 and 11 both give the short buffer
  assign depth_d = (f_depth == 2'b00) ? DEPTH_DEEP :
                   (f_depth == 2'b01) ? DEPTH_MID : DEPTH_SHORT;

  assign corner_d = f_bw ? (line_std_q ? CORNER_T1_HI : CORNER_E1_HI) :
                           (line_std_q ? CORNER_T1_LO : CORNER_E1_LO);

  assign bypass_d = f_mode[1];
  assign subst_d  = (f_mode == MODE_SUBST);
  assign ami_d    = (f_mode == MODE_AMI);

  // registered so the datapath sees clean levels
  always_ff @(posedge clock) begin
    if (reset) begin
      tx_t1_mode             <= 1'b0;
      tx_atten_enable        <= 1'b0;
      tx_atten_wide_limit    <= RST_TJA_CFG[BIT_ATT_WIDE];
      tx_jitter_measure_mode <= 1'b0;
      tx_atten_depth_bits    <= DEPTH_DEEP;
      tx_atten_corner_mhz    <= CORNER_E1_LO;
    end else begin
      tx_t1_mode             <= line_std_q;
      tx_atten_enable        <= f_att_en;
      tx_atten_wide_limit    <= f_wide;
      tx_jitter_measure_mode <= f_measure;
      tx_atten_depth_bits    <= depth_d;
      tx_atten_corner_mhz    <= corner_d;
    end
  end

  // encoder stage selection and power state
  always_ff @(posedge clock) begin
    if (reset) begin
      tx_subst_hdb3     <= 1'b0;
      tx_subst_b8zs     <= 1'b0;
      tx_ami_en         <= 1'b0;
      tx_shaper_en      <= 1'b0;
      tx_encoder_bypass <= 1'b0;
      tx_power_down     <= 1'b0;
      tx_driver_oe      <= 1'b0;
    end else begin
      tx_subst_hdb3     <= subst_d & ~line_std_q;
      tx_subst_b8zs     <= subst_d & line_std_q;
      tx_ami_en         <= ami_d;
      tx_shaper_en      <= ~bypass_d;
      tx_encoder_bypass <= bypass_d;
      tx_power_down     <= f_pdown;
      tx_driver_oe      <= ~f_pdown;
    end
  end

  // ==========================================================
  // pin synchronisers: clock, single, positive, negative
  localparam int NPIN = 4;

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1_q;
  logic [NPIN-1:0] pin_s2_q;
  logic [NPIN-1:0] pin_s3_q;
  logic [NPIN-1:0] pin_val_q;
  logic [NPIN-1:0] pin_val_d;

  assign pin_raw = {tx_negative_rail_data, tx_positive_rail_data,
                    tx_single_rail_data, tx_channel_clock};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_sync
      // a change counts only once stages two and three agree
      assign pin_val_d[gi] = (pin_s2_q[gi] == pin_s3_q[gi]) ?
                             pin_s3_q[gi] : pin_val_q[gi];

      always_ff @(posedge clock) begin
        if (reset) begin
          pin_s1_q[gi]  <= 1'b0;
          pin_s2_q[gi]  <= 1'b0;
          pin_s3_q[gi]  <= 1'b0;
          pin_val_q[gi] <= 1'b0;
        end else begin
          pin_s1_q[gi]  <= pin_raw[gi];
          pin_s2_q[gi]  <= pin_s1_q[gi];
          pin_s3_q[gi]  <= pin_s2_q[gi];
          pin_val_q[gi] <= pin_val_d[gi];
        end
      end
    end
  endgenerate

  // ==========================================================
  // sampling edge; the data pins share the clock pin's latency so
  // setup is preserved, but the pin clock must stay well below the
  // system clock for every edge to be seen
  logic take_bit;
  logic clk_edge;

  assign clk_edge = pin_val_d[0] ^ pin_val_q[0];
  assign take_bit = clk_edge & (pin_val_d[0] == f_edge) & ~f_pdown;

  // polarity applied before encoding
  logic nrz_single;
  logic nrz_pos;
  logic nrz_neg;

  assign nrz_single = pin_val_d[1] ^ f_invert;
  assign nrz_pos    = pin_val_d[2] ^ f_invert;
  assign nrz_neg    = pin_val_d[3] ^ f_invert;

  // ==========================================================
  // line coding: marks alternate polarity in both encoder modes;
  // the zero-string substitution downstream keys off the enables
  logic mark_pol_q;
  logic line_pos_d;
  logic line_neg_d;

  assign line_pos_d = bypass_d ? nrz_pos : (nrz_single & ~mark_pol_q);
  assign line_neg_d = bypass_d ? nrz_neg : (nrz_single & mark_pol_q);

  // mark polarity only moves when a mark is sent single rail
  always_ff @(posedge clock) begin
    if (reset) begin
      mark_pol_q <= 1'b0;
    end else if (take_bit && !bypass_d && nrz_single) begin
      mark_pol_q <= ~mark_pol_q;
    end
  end

  // output rails hold until the next bit, and go quiet when powered down
  always_ff @(posedge clock) begin
    if (reset) begin
      tx_line_pos   <= 1'b0;
      tx_line_neg   <= 1'b0;
      tx_bit_strobe <= 1'b0;
    end else if (f_pdown) begin
      tx_line_pos   <= 1'b0;
      tx_line_neg   <= 1'b0;
      tx_bit_strobe <= 1'b0;
    end else begin
      tx_line_pos   <= take_bit ? line_pos_d : tx_line_pos;
      tx_line_neg   <= take_bit ? line_neg_d : tx_line_neg;
      tx_bit_strobe <= take_bit;
    end
  end

endmodule

// file: testbench/tpc_tx_monitor.sv
// port checker for the transmit path configuration block
// assumes binding onto tpc_tx_path_config, one clock, synchronous reset
`timescale 1ns/1ps
module tpc_tx_monitor
  import tpc_pkg::*;
#(
  parameter int PERIOD_CYCLES = TIMER_CYCLES
) (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        reg_cs,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic        timer_irq,
  input wire logic        tx_bit_strobe,
  input wire logic        tx_line_pos,
  input wire logic        tx_line_neg,
  input wire logic        tx_driver_oe,
  input wire logic        tx_power_down,
  input wire logic        tx_t1_mode,
  input wire logic        tx_subst_hdb3,
  input wire logic        tx_subst_b8zs,
  input wire logic        tx_ami_en,
  input wire logic        tx_shaper_en,
  input wire logic        tx_encoder_bypass
);
  // ==========================================================
  // shadow of the interrupt enable, rebuilt from host writes only
  logic en_q;
  logic en_d;
  wire  en_write = reg_cs && reg_wr && reg_addr == ADDR_TIMER_EN;
  assign en_d = en_write ? reg_wdata[BIT_TIMER_EN] : en_q;
  always_ff @(posedge clock) begin
    en_q <= reset ? 1'b0 : en_d;
  end

  // ==========================================================
  // properties; outputs settle one edge after reset lets go
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  a_irq_masked : assert property (timer_irq |-> en_q)
    else $error("timer interrupt while masked");
  a_status_rsvd : assert property (reg_cs && reg_rd && reg_addr == ADDR_TIMER_ST
    |=> reg_rvalid && reg_rdata[7:1] == 7'h00) else $error("status reserved bits set");
  a_flag_shown : assert property (reg_cs && reg_rd && reg_addr == ADDR_TIMER_ST
    && timer_irq |=> reg_rdata[0]) else $error("interrupt without flag");
  a_pdown_oe : assert property (!$past(reset) |-> tx_driver_oe != tx_power_down)
    else $error("driver enable disagrees with power down");
  a_pdown_quiet : assert property (tx_power_down [*3]
    |-> !tx_bit_strobe && !tx_line_pos && !tx_line_neg) else $error("powered down output");
  a_bypass_shaper : assert property (!$past(reset) |-> tx_shaper_en != tx_encoder_bypass)
    else $error("shaper and bypass disagree");
  a_subst_std : assert property (tx_subst_hdb3 || tx_subst_b8zs
    |-> tx_subst_b8zs == tx_t1_mode && !tx_ami_en) else $error("wrong substitution code");
  a_ami_path : assert property (tx_ami_en |-> tx_shaper_en && !tx_encoder_bypass)
    else $error("ami without shaper");
  a_strobe_pulse : assert property (tx_bit_strobe |=> !tx_bit_strobe [*8])
    else $error("strobe longer than one cycle");
  c_irq : cover property ($rose(timer_irq));
  c_ami_bit : cover property (tx_bit_strobe && tx_ami_en);
  c_dual_bit : cover property (tx_bit_strobe && tx_encoder_bypass);
  c_pdown : cover property (tx_power_down);
endmodule

// file: testbench/tpc_tx_source.sv
// system side transmit source: slow pin clock with data timed to one edge
// assumes the bench system clock for pacing; the pin clock stands between bits
`timescale 1ns/1ps
module tpc_tx_source (
  input  wire logic clock,
  output logic      tx_channel_clock,
  output logic      tx_single_rail_data,
  output logic      tx_positive_rail_data,
  output logic      tx_negative_rail_data
);
  initial begin
    tx_channel_clock      = 1'b0;
    tx_single_rail_data   = 1'b0;
    tx_positive_rail_data = 1'b0;
    tx_negative_rail_data = 1'b0;
  end

  // ==========================================================
  // one bit: park opposite the chosen edge, set data, make the edge;
  // eight clocks a phase stays well clear of the synchroniser limit
  task automatic send_bit(input logic rise, input logic d, input logic p, input logic n);
    tx_channel_clock = ~rise;
    repeat (8) @(negedge clock);
    tx_single_rail_data   = d;
    tx_positive_rail_data = p;
    tx_negative_rail_data = n;
    repeat (8) @(negedge clock);
    tx_channel_clock = rise;
    repeat (8) @(negedge clock);
    // hold time is over: stale data must not look valid
    tx_single_rail_data   = ~d;
    tx_positive_rail_data = ~p;
    tx_negative_rail_data = ~n;
  endtask
endmodule

// file: testbench/tx_path_config_and_timer_irq_test.sv
// self-checking bench for the transmit path configuration block
// assumes tpc_pkg, the design, the source model and the monitor compiled first
`timescale 1ns/1ps
module tx_path_config_and_timer_irq_test;
  import tpc_pkg::*;
  localparam int         PERIOD = 400;
  localparam logic [3:0] CH     = 4'h2;
  logic        clock = 1'b0, reset = 1'b1, reg_cs = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata, tx_atten_depth_bits;
  logic [12:0] tx_atten_corner_mhz;
  logic        reg_rvalid, timer_irq, tx_channel_clock, tx_single_rail_data;
  logic        tx_positive_rail_data, tx_negative_rail_data, tx_bit_strobe, tx_line_pos;
  logic        tx_line_neg, tx_driver_oe, tx_power_down, tx_t1_mode, tx_subst_hdb3;
  logic        tx_subst_b8zs, tx_ami_en, tx_shaper_en, tx_encoder_bypass;
  logic        tx_atten_enable, tx_atten_wide_limit, tx_jitter_measure_mode;
  int          n_fail = 0, tests_run = 0, n_strobe = 0;

  always #5 clock = ~clock;
  // strobes are counted so that a missing or doubled bit shows up
  always @(posedge clock) if (tx_bit_strobe === 1'b1) n_strobe++;

  tpc_tx_path_config #(.CHANNEL(CH), .PERIOD_CYCLES(PERIOD)) u_dut (
    .clock, .reset, .reg_cs, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_rvalid, .timer_irq, .tx_channel_clock, .tx_single_rail_data,
    .tx_positive_rail_data, .tx_negative_rail_data, .tx_bit_strobe, .tx_line_pos,
    .tx_line_neg, .tx_driver_oe, .tx_power_down, .tx_t1_mode, .tx_subst_hdb3,
    .tx_subst_b8zs, .tx_ami_en, .tx_shaper_en, .tx_encoder_bypass, .tx_atten_enable,
    .tx_atten_wide_limit, .tx_jitter_measure_mode, .tx_atten_depth_bits,
    .tx_atten_corner_mhz);
  tpc_tx_source u_src (.clock, .tx_channel_clock, .tx_single_rail_data,
    .tx_positive_rail_data, .tx_negative_rail_data);

  // ==========================================================
  // reporting
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic timeout();
    n_fail++;
    results();
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  initial begin
    repeat (60000) @(posedge clock);
    timeout();
  end

  // ==========================================================
  // host port: requests launched on the falling edge, two idle cycles after a write, one after a read
  function automatic logic [11:0] ca(input logic [7:0] ofs);
    return {CH, ofs};
  endfunction
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    reg_cs    = 1'b1;
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge clock);
    reg_cs = 1'b0;
    reg_wr = 1'b0;
    repeat (2) @(negedge clock);
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    int i;
    reg_cs   = 1'b1;
    reg_rd   = 1'b1;
    reg_addr = a;
    @(negedge clock);
    reg_cs = 1'b0;
    reg_rd = 1'b0;
    for (i = 0; i < 4 && reg_rvalid !== 1'b1; i++) @(negedge clock);
    if (i == 4) timeout();
    d = reg_rdata;
    @(negedge clock);
  endtask
  task automatic rc(input logic [11:0] a, input logic [7:0] e, input string what);
    logic [7:0] d;
    rd(a, d);
    check(what, d, e);
  endtask
  // one transmit bit; e holds {one strobe seen, pos rail, neg rail}
  task automatic tx(input logic rise, input logic [2:0] dpn, input logic [2:0] e);
    int s0;
    s0 = n_strobe;
    u_src.send_bit(rise, dpn[2], dpn[1], dpn[0]);
    check("tx bit", {n_strobe - s0 == 1, tx_line_pos, tx_line_neg}, e);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    rc(ADDR_TIMER_EN, 8'h00, "timer enable");
    rc(ADDR_TIMER_ST, 8'h00, "timer flag");
    rc(ca(OFS_LINE_STD), 8'h00, "line std");
    rc(ca(OFS_TJA_CFG), 8'h10, "tja cfg");
    rc(ca(OFS_TX_CFG0), 8'h00, "tx cfg0");
    check("reset outs", {tx_driver_oe, tx_subst_hdb3, tx_shaper_en, tx_t1_mode}, 4'hE);
    check("reset depth", tx_atten_depth_bits, 8'h80);
  endtask
  task automatic t_rsvd();
    wr(ADDR_TIMER_EN, 8'hFE);
    rc(ADDR_TIMER_EN, 8'h00, "enable rsvd");
    wr(ca(OFS_LINE_STD), 8'hFE);
    rc(ca(OFS_LINE_STD), 8'h00, "std rsvd");
    wr({4'h3, OFS_TX_CFG0}, 8'h1F);
    rc(ca(OFS_TX_CFG0), 8'h00, "other page");
    rc({4'h3, OFS_TX_CFG0}, 8'h00, "other page read");
    wr(ca(8'h30), 8'hFF);
    rc(ca(8'h30), 8'h00, "unmapped");
    wr(ca(OFS_TX_CFG0), 8'hE0);
    rc(ca(OFS_TX_CFG0), 8'h00, "cfg0 rsvd");
  endtask
  // every depth code and both bandwidths under each standard
  task automatic t_atten();
    logic [7:0]  v;
    logic [7:0]  ed;
    logic [12:0] ec;
    for (int i = 0; i < 16; i++) begin
      v  = {2'b11, i[0], ~i[0], i[1], i[2:1], i[0]};
      ed = v[2:1] == 2'b00 ? DEPTH_DEEP : (v[2:1] == 2'b01 ? DEPTH_MID : DEPTH_SHORT);
      ec = v[0] ? (i[3] ? CORNER_T1_HI : CORNER_E1_HI) : (i[3] ? CORNER_T1_LO : CORNER_E1_LO);
      wr(ca(OFS_LINE_STD), {7'h00, i[3]});
      wr(ca(OFS_TJA_CFG), v);
      rc(ca(OFS_TJA_CFG), {2'b00, v[5:0]}, "tja read");
      check("tja bits", {tx_jitter_measure_mode, tx_atten_wide_limit, tx_atten_enable}, v[5:3]);
      check("depth", tx_atten_depth_bits, ed);
      check("corner", tx_atten_corner_mhz, ec);
      check("std", tx_t1_mode, i[3]);
    end
    wr(ca(OFS_TJA_CFG), 8'h10);
  endtask
  task automatic t_modes();
    logic [5:0] e;
    for (int i = 0; i < 8; i++) begin
      e = {i[2], i[1:0] == 0 && !i[2], i[1:0] == 0 && i[2], i[1:0] == 1, !i[1], i[1]};
      wr(ca(OFS_LINE_STD), {7'h00, i[2]});
      wr(ca(OFS_TX_CFG0), {6'h00, i[1:0]});
      check("modes", {tx_t1_mode, tx_subst_hdb3, tx_subst_b8zs, tx_ami_en, tx_shaper_en,
        tx_encoder_bypass}, e);
    end
    wr(ca(OFS_LINE_STD), 8'h00);
  endtask
  // marks alternate; the unselected pin edge must not send a bit
  task automatic t_stream();
    wr(ca(OFS_TX_CFG0), 8'h05);
    tx(1'b1, 3'b100, 3'b110);
    tx(1'b1, 3'b000, 3'b100);
    tx(1'b1, 3'b100, 3'b101);
    wr(ca(OFS_TX_CFG0), 8'h08);
    tx(1'b0, 3'b000, 3'b110);
    tx(1'b0, 3'b100, 3'b100);
    wr(ca(OFS_TX_CFG0), 8'h06);
    tx(1'b1, 3'b010, 3'b110);
    tx(1'b1, 3'b001, 3'b101);
    wr(ca(OFS_TX_CFG0), 8'h0E);
    tx(1'b1, 3'b001, 3'b110);
  endtask
  task automatic t_pdown();
    wr(ca(OFS_TX_CFG0), 8'h15);
    check("pdown", {tx_power_down, tx_driver_oe}, 2'b10);
    tx(1'b1, 3'b100, 3'b000);
    wr(ca(OFS_TX_CFG0), 8'h05);
    check("pdown", {tx_power_down, tx_driver_oe}, 2'b01);
  endtask
  task automatic wait_irq();
    int i;
    for (i = 0; i < 1000 && timer_irq !== 1'b1; i++) @(negedge clock);
    if (i == 1000) timeout();
  endtask
  // flag sets while masked, clears on a one only, repeats each period
  task automatic t_timer();
    logic [7:0] d;
    int         i;
    time        t0;
    d = 8'h00;
    for (i = 0; i < 300 && d !== 8'h01; i++) rd(ADDR_TIMER_ST, d);
    if (i == 300) timeout();
    check("masked irq", timer_irq, 1'b0);
    wr(ADDR_TIMER_EN, 8'h01);
    check("irq", timer_irq, 1'b1);
    // clear, then work right after a fresh expiry so none lands mid-check
    wr(ADDR_TIMER_ST, 8'h01);
    wait_irq();
    wr(ADDR_TIMER_ST, 8'hFE);
    rc(ADDR_TIMER_ST, 8'h01, "flag kept");
    wr(ADDR_TIMER_ST, 8'h01);
    rc(ADDR_TIMER_ST, 8'h00, "flag cleared");
    check("irq cleared", timer_irq, 1'b0);
    wait_irq();
    t0 = $time;
    wr(ADDR_TIMER_ST, 8'h01);
    wait_irq();
    check("timer period", 16'(($time - t0) / 10), 16'(PERIOD));
    wr(ADDR_TIMER_EN, 8'h00);
    check("irq masked", timer_irq, 1'b0);
    rc(ADDR_TIMER_ST, 8'h01, "flag stays");
    wr(ADDR_TIMER_ST, 8'h01);
  endtask

  initial begin
    repeat (4) @(negedge clock);
    reset = 1'b0;
    @(negedge clock);
    t_reset();
    t_rsvd();
    t_atten();
    t_modes();
    t_stream();
    t_pdown();
    t_timer();
    results();
  end
endmodule

bind tpc_tx_path_config tpc_tx_monitor #(.PERIOD_CYCLES(PERIOD_CYCLES)) u_mon (
  .clock, .reset, .reg_cs, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
  .reg_rvalid, .timer_irq, .tx_bit_strobe, .tx_line_pos, .tx_line_neg, .tx_driver_oe,
  .tx_power_down, .tx_t1_mode, .tx_subst_hdb3, .tx_subst_b8zs, .tx_ami_en,
  .tx_shaper_en, .tx_encoder_bypass);
